// File: sim/tap_driver.sv
`timescale 1ns/100ps
module tap_driver (
    input wire logic mclk_in,              // System clock that paces the test clock.
    input wire logic tdo_in,               // Serial data from the device.
    input wire logic tdo_oe_n_in,          // Low while the device drives its serial output.
    output jtag_pkg::jtag_pins_s pins_out  // Test clock, mode, data and reset pins.
);
    import jtag_pkg::*;

    logic last_tdo;
    logic last_oe_n;

    // ------------------------------------------------------------
    // Test clock cycles.
    // ------------------------------------------------------------
    // The test clock stands low between calls, as a real controller leaves it.
    initial begin
        pins_out = PINS_IDLE;
    end

    // One cycle of 200 ns. The serial output is taken late in the high phase, clear of the
    // fall that launches the next bit.
    task automatic tick(input logic tms, input logic tdi);
        @(posedge mclk_in);
        pins_out.tms <= tms;
        pins_out.tdi <= tdi;
        repeat (3) @(posedge mclk_in);
        pins_out.tck <= 1'b1;
        repeat (4) @(posedge mclk_in);
        // A released TDO reads as the inverse, so a missing enable corrupts the data.
        last_tdo = tdo_oe_n_in ? ~tdo_in : tdo_in;
        last_oe_n = tdo_oe_n_in;
        pins_out.tck <= 1'b0;
    endtask : tick

    // Five mode-high cycles, then one low cycle to park in Run-Test-Idle.
    task automatic tms_reset();
        for (int i = 0; i < 5; i++) begin
            tick(1'b1, ~pins_out.tdi);
        end
        tick(1'b0, ~pins_out.tdi);
    endtask : tms_reset

    // Reset pulse of 200 ns with 100 ns of recovery before the next cycle.
    task automatic trst_pulse();
        @(posedge mclk_in);
        pins_out.trst_n <= 1'b0;
        repeat (8) @(posedge mclk_in);
        pins_out.trst_n <= 1'b1;
        repeat (4) @(posedge mclk_in);
        tick(1'b0, ~pins_out.tdi);
    endtask : trst_pulse

    // One scan from Run-Test-Idle back to Run-Test-Idle, data LSB first. Idle cycles put the
    // inverse of the previous TDI level on the line so a stale value is never mistaken for data.
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout, output logic oe_bad);
        dout = '0;
        oe_bad = 1'b0;
        tick(1'b1, ~pins_out.tdi);
        if (ir) begin
            tick(1'b1, ~pins_out.tdi);
        end
        tick(1'b0, ~pins_out.tdi);
        tick(1'b0, ~pins_out.tdi);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i]);
            dout[i] = last_tdo;
            oe_bad = oe_bad | last_oe_n;
        end
        tick(1'b1, ~pins_out.tdi);
        tick(1'b0, ~pins_out.tdi);
    endtask : scan

endmodule : tap_driver

// File: sim/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) check_val(64'(g), 64'(e))
module tb;
    import jtag_pkg::*;

    localparam int NI = 4;
    localparam int NO = 4;
    localparam int NC = NI + 2 * NO;
    localparam logic [VER_W-1:0] T_VER = 4'h6;        // Arbitrary value.
    localparam logic [PART_W-1:0] T_PART = 16'hC0DE;  // Arbitrary value.
    localparam logic [MFR_W-1:0] T_MAKER = 11'h2A5;   // Arbitrary value.
    localparam logic [31:0] ID_EXP = {T_VER, T_PART, T_MAKER, 1'h1};

    logic mclk = 1'b0;
    logic rst = 1'b1;
    jtag_pins_s pins;
    logic tdo;
    logic tdo_oe_n;
    logic [NI-1:0] pin_in = 4'hC;
    logic [NI-1:0] core_in;
    logic [NO-1:0] core_out = 4'h9;
    logic [NO-1:0] core_oe_n = 4'h9;
    logic [NO-1:0] pin_out;
    logic [NO-1:0] pin_oe_n;
    logic [63:0] d;
    logic b;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    // ------------------------------------------------------------
    // Device, test controller and clock.
    // ------------------------------------------------------------
    jtag_test_port #(.N_IN(NI), .N_OUT(NO), .VERSION(T_VER), .PART(T_PART),
                     .MAKER(T_MAKER)) DUT (
        .mclk_in(mclk), .rst_in(rst), .jtag_in(pins), .tdo_out(tdo),
        .tdo_oe_n_out(tdo_oe_n), .pin_in(pin_in), .core_in_out(core_in),
        .core_out_in(core_out), .core_oe_n_in(core_oe_n), .pin_out(pin_out),
        .pin_oe_n_out(pin_oe_n)
    );

    tap_driver ctl (.mclk_in(mclk), .tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n), .pins_out(pins));

    // A 40 MHz clock; the cycle limit cuts a hung run short.
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_val

    // Pins follow the instruction one cycle after the latch, so a few cycles are allowed.
    task automatic settle();
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    task automatic load_ir(input logic [3:0] code);
        ctl.scan(1'b1, 4, 64'(code), d, b);
        settle();
    endtask : load_ir

    // All ones go in, so a writable identity word would show up on the next scan.
    task automatic id_scan();
        ctl.scan(1'b0, 32, 64'hFFFF_FFFF, d, b);
        settle();
    endtask : id_scan

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic test_power_up();
        ctl.tick(1'b0, 1'b0);
        id_scan();
        `CHK(d[31:0], ID_EXP);
        `CHK(d[11:1], T_MAKER);
        `CHK(b, 1'b0);
        `CHK(tdo_oe_n, 1'b1);
        `CHK(pin_out, core_out);
        `CHK(pin_oe_n, core_oe_n);
        id_scan();
        `CHK(d[31:0], ID_EXP);
    endtask : test_power_up

    // Eight bits through a four-bit register: capture first, then the first four sent.
    task automatic test_ir();
        load_ir(4'hF);
        ctl.scan(1'b1, 8, 64'h2F, d, b);
        settle();
        `CHK(d[1:0], 2'b01);
        `CHK(d[7:4], 4'hF);
        `CHK(b, 1'b0);
        id_scan();
        `CHK(d[31:0], ID_EXP);
    endtask : test_ir

    // Every code that lands on the single stage, unknown codes included.
    task automatic test_bypass_codes();
        for (int c = 3; c < 16; c++) begin
            load_ir(4'(c));
            if (c == 3) begin
                `CHK(pin_oe_n, 4'hF);
                @(posedge mclk) core_oe_n <= 4'h0;
            end
            ctl.scan(1'b0, 8, 64'hB4, d, b);
            settle();
            `CHK(d[7:0], 8'h68);
            if (c == 15) `CHK(d[7:0], 8'h68);
            if (c == 3) `CHK(pin_oe_n, 4'hF);
            else `CHK(pin_oe_n, core_oe_n);
            if (c != 3) `CHK(pin_out, core_out);
            @(posedge mclk) core_oe_n <= 4'h9;
        end
    endtask : test_bypass_codes

    // Preload under sample, then drive the pins from the chain under external test.
    task automatic test_boundary();
        @(posedge mclk) begin
            pin_in <= 4'h3;
            core_out <= 4'hA;
            core_oe_n <= 4'h5;
        end
        load_ir(4'h1);
        ctl.scan(1'b0, NC, 64'h6C9, d, b);
        settle();
        `CHK(d[11:0], 12'h5A3);
        `CHK(pin_out, 4'hA);
        `CHK(core_in, 4'h3);
        load_ir(4'h0);
        `CHK(pin_out, 4'hC);
        `CHK(pin_oe_n, 4'h6);
        ctl.scan(1'b0, NC, 64'h0F0, d, b);
        settle();
        `CHK(d[11:0], 12'h5A3);
        `CHK(pin_out, 4'hF);
        `CHK(pin_oe_n, 4'h0);
    endtask : test_boundary

    task automatic test_resets();
        load_ir(4'hF);
        ctl.tms_reset();
        id_scan();
        `CHK(d[31:0], ID_EXP);
        load_ir(4'hF);
        ctl.trst_pulse();
        id_scan();
        `CHK(d[31:0], ID_EXP);
    endtask : test_resets

    // ------------------------------------------------------------
    // Main sequence and verdict.
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        test_power_up();
        test_ir();
        test_bypass_codes();
        test_boundary();
        test_resets();
        complete_run();
    end

endmodule : tb

// File: src/bsr_chain.sv
`timescale 1ns/100ps
module bsr_chain #(
    parameter int N = 8
) (
    input wire logic mclk_in,          // System clock.
    input wire logic rst_in,           // Synchronous reset, active high.
    input wire logic cap_in,           // Capture pulse.
    input wire logic shift_in,         // Shift pulse.
    input wire logic upd_in,           // Update pulse.
    input wire logic tdi_in,           // Serial data in.
    input wire logic [N-1:0] par_in,   // Values captured from the cells.
    output logic so_out,               // Serial data out, cell 0.
    output logic [N-1:0] upd_out       // Update latch bank.
);
    import jtag_pkg::*;

    typedef struct packed {
        logic [N-1:0] sh;
        logic [N-1:0] up;
    } bsr_regs_s;

    bsr_regs_s r;
    bsr_regs_s r_nxt;

    // ------------------------------------------------------------
    // Shift bank and update bank.
    // ------------------------------------------------------------
    // The update bank only moves on update, so shifting never
    // glitches the pins that EXTEST drives.
    always_comb begin
        r_nxt = r;
        if (cap_in) begin
            r_nxt.sh = par_in;
        end else if (shift_in) begin
            r_nxt.sh = {tdi_in, r.sh[N-1:1]};
        end
        if (upd_in) begin
            r_nxt.up = r.sh;
        end
    end

    // State register.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign so_out = r.sh[0];
    assign upd_out = r.up;

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    AST_BSR_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
        !cap_in && !shift_in |=> r.sh == $past(r.sh))
        else $error("Boundary chain moved while not selected.");

endmodule : bsr_chain

// File: src/jtag_pkg.sv
package jtag_pkg;

    // ------------------------------------------------------------
    // Widths and identification word layout.
    // ------------------------------------------------------------
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam int VER_W = 4;
    localparam int PART_W = 16;
    localparam int MFR_W = 11;
    localparam int VER_LSB = 28;
    localparam int PART_LSB = 12;
    localparam int MFR_LSB = 1;
    localparam logic ID_MARKER = 1'h1;

    // ------------------------------------------------------------
    // Instruction codes and fixed capture pattern.
    // ------------------------------------------------------------
    localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] IR_HIGHZ = 4'h3;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h5;
    localparam logic [IR_W-1:0] IR_RESET = IR_IDCODE;

    // ------------------------------------------------------------
    // Controller states and serial path selection.
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
        SH_DR = 4'h4, EX1_DR = 4'h5, PAU_DR = 4'h6, EX2_DR = 4'h7,
        UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
        EX1_IR = 4'hC, PAU_IR = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF
    } tap_state_e;

    typedef enum logic [1:0] {
        SEL_BSR = 2'h0,
        SEL_ID = 2'h1,
        SEL_BYP = 2'h2
    } dr_sel_e;

    // Test port pins as seen at the device boundary.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } jtag_pins_s;

    localparam jtag_pins_s PINS_IDLE = 4'h1;

endpackage : jtag_pkg

// File: src/jtag_test_port.sv
`timescale 1ns/100ps
module jtag_test_port #(
    parameter int N_IN = 4,                        // Input pin cells.
    parameter int N_OUT = 4,                       // Output pin cells.
    parameter logic [jtag_pkg::VER_W-1:0] VERSION = 4'h1,    // Arbitrary value.
    parameter logic [jtag_pkg::PART_W-1:0] PART = 16'h1234,  // Arbitrary value.
    parameter logic [jtag_pkg::MFR_W-1:0] MAKER = 11'h155    // Arbitrary value.
) (
    input wire logic mclk_in,                      // System clock, 40 MHz.
    input wire logic rst_in,                       // Synchronous reset.
    input wire jtag_pkg::jtag_pins_s jtag_in,      // Test port pins.
    output logic tdo_out,                          // Serial data out.
    output logic tdo_oe_n_out,                     // Low while TDO drives.
    input wire logic [N_IN-1:0] pin_in,            // Input pin levels.
    output logic [N_IN-1:0] core_in_out,           // Pin levels to the core.
    input wire logic [N_OUT-1:0] core_out_in,      // Core output data.
    input wire logic [N_OUT-1:0] core_oe_n_in,     // Core output enables.
    output logic [N_OUT-1:0] pin_out,              // Output pin data.
    output logic [N_OUT-1:0] pin_oe_n_out          // Output pin enables.
);
    import jtag_pkg::*;

    localparam int N_BSR = N_IN + 2 * N_OUT;

    // ------------------------------------------------------------
    // Parameter checks.
    // ------------------------------------------------------------
    if (N_IN < 1 || N_OUT < 1) begin : g_bad_cells
        $error("Each pin group needs at least one cell.");
    end

    // The identity fields are package widths; any change there must still fill the word.
    if (VER_W + PART_W + MFR_W + 1 != ID_W) begin : g_bad_id
        $error("Identity fields do not fill the identity word.");
    end

    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    // Next controller state for a given TMS level.
    function automatic tap_state_e tap_next(input tap_state_e s, input logic tms);
        case (s)
            TLR: tap_next = tms ? TLR : RTI;
            RTI: tap_next = tms ? SEL_DR : RTI;
            SEL_DR: tap_next = tms ? SEL_IR : CAP_DR;
            CAP_DR: tap_next = tms ? EX1_DR : SH_DR;
            SH_DR: tap_next = tms ? EX1_DR : SH_DR;
            EX1_DR: tap_next = tms ? UPD_DR : PAU_DR;
            PAU_DR: tap_next = tms ? EX2_DR : PAU_DR;
            EX2_DR: tap_next = tms ? UPD_DR : SH_DR;
            UPD_DR: tap_next = tms ? SEL_DR : RTI;
            SEL_IR: tap_next = tms ? TLR : CAP_IR;
            CAP_IR: tap_next = tms ? EX1_IR : SH_IR;
            SH_IR: tap_next = tms ? EX1_IR : SH_IR;
            EX1_IR: tap_next = tms ? UPD_IR : PAU_IR;
            PAU_IR: tap_next = tms ? EX2_IR : PAU_IR;
            EX2_IR: tap_next = tms ? UPD_IR : SH_IR;
            UPD_IR: tap_next = tms ? SEL_DR : RTI;
            default: tap_next = TLR;
        endcase
    endfunction : tap_next

    // Serial data path chosen by an instruction.
    function automatic dr_sel_e dr_sel(input logic [IR_W-1:0] ir);
        case (ir)
            IR_EXTEST: dr_sel = SEL_BSR;
            IR_SAMPLE: dr_sel = SEL_BSR;
            IR_IDCODE: dr_sel = SEL_ID;
            IR_HIGHZ: dr_sel = SEL_BYP;
            IR_BYPASS: dr_sel = SEL_BYP;
            default: dr_sel = SEL_BYP;
        endcase
    endfunction : dr_sel

    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    typedef struct packed {
        jtag_pins_s s1;
        jtag_pins_s s2;
        logic tck3;
        tap_state_e st;
        logic [IR_W-1:0] ir_sh;
        logic [IR_W-1:0] ir_lat;
        logic byp;
        logic [ID_W-1:0] id_sh;
        logic tdo;
        logic tdo_oe_n;
        logic [N_IN-1:0] pin1;
        logic [N_IN-1:0] pin2;
        logic [N_IN-1:0] core_in;
        logic [N_OUT-1:0] pout;
        logic [N_OUT-1:0] poe_n;
    } port_regs_s;

    port_regs_s r;
    port_regs_s r_nxt;

    // The maker code goes in without its parity bit.
    logic [ID_W-1:0] id_word;
    assign id_word = {VERSION, PART, MAKER, ID_MARKER};

    logic rise;
    logic fall;
    logic trst;
    dr_sel_e sel;
    logic bsr_cap;
    logic bsr_shift;
    logic bsr_upd;
    logic bsr_so;
    logic [N_BSR-1:0] bsr_par;
    logic [N_BSR-1:0] bsr_up;

    // TCK edges are taken from the second and third stages only.
    assign rise = r.s2.tck && !r.tck3;
    assign fall = !r.s2.tck && r.tck3;
    assign trst = !r.s2.trst_n;
    assign sel = dr_sel(r.ir_lat);

    // ------------------------------------------------------------
    // Boundary-scan chain: inputs nearest TDO, then data, then enables.
    // ------------------------------------------------------------
    assign bsr_par = {core_oe_n_in, core_out_in, r.pin2};
    assign bsr_cap = rise && r.st == CAP_DR && sel == SEL_BSR;
    assign bsr_shift = rise && r.st == SH_DR && sel == SEL_BSR;
    assign bsr_upd = fall && r.st == UPD_DR && sel == SEL_BSR;

    bsr_chain #(
        .N(N_BSR)
    ) u_bsr (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .cap_in(bsr_cap),
        .shift_in(bsr_shift),
        .upd_in(bsr_upd),
        .tdi_in(r.s2.tdi),
        .par_in(bsr_par),
        .so_out(bsr_so),
        .upd_out(bsr_up)
    );

    // ------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------
    always_comb begin
        r_nxt = r;
        r_nxt.s1 = jtag_in;
        r_nxt.s2 = r.s1;
        r_nxt.tck3 = r.s2.tck;
        r_nxt.pin1 = pin_in;
        r_nxt.pin2 = r.pin1;
        r_nxt.core_in = r.pin2;
        // Rising TCK: capture, shift and move the controller.
        if (rise) begin
            case (r.st)
                CAP_IR: r_nxt.ir_sh = IR_CAPTURE;
                SH_IR: r_nxt.ir_sh = {r.s2.tdi, r.ir_sh[IR_W-1:1]};
                CAP_DR: begin
                    if (sel == SEL_BYP) begin
                        r_nxt.byp = 1'h0;
                    end
                    if (sel == SEL_ID) begin
                        r_nxt.id_sh = id_word;
                    end
                end
                SH_DR: begin
                    if (sel == SEL_BYP) begin
                        r_nxt.byp = r.s2.tdi;
                    end
                    if (sel == SEL_ID) begin
                        r_nxt.id_sh = {r.s2.tdi, r.id_sh[ID_W-1:1]};
                    end
                end
                default: r_nxt.byp = r.byp;
            endcase
            r_nxt.st = tap_next(r.st, r.s2.tms);
        end
        // Falling TCK: instruction update and TDO launch.
        if (fall) begin
            if (r.st == TLR) begin
                r_nxt.ir_lat = IR_RESET;
            end else if (r.st == UPD_IR) begin
                r_nxt.ir_lat = r.ir_sh;
            end
            r_nxt.tdo_oe_n = 1'h1;
            r_nxt.tdo = 1'h0;
            if (r.st == SH_IR) begin
                r_nxt.tdo_oe_n = 1'h0;
                r_nxt.tdo = r.ir_sh[0];
            end else if (r.st == SH_DR) begin
                r_nxt.tdo_oe_n = 1'h0;
                case (sel)
                    SEL_BSR: r_nxt.tdo = bsr_so;
                    SEL_ID: r_nxt.tdo = r.id_sh[0];
                    default: r_nxt.tdo = r.byp;
                endcase
            end
        end
        // The TRST pin wins over any TCK activity.
        if (trst) begin
            r_nxt.st = TLR;
            r_nxt.ir_lat = IR_RESET;
        end
        // Pin drivers: the core owns them except under EXTEST and HIGH-Z.
        if (r.ir_lat == IR_EXTEST) begin
            r_nxt.pout = bsr_up[N_IN +: N_OUT];
            r_nxt.poe_n = bsr_up[N_IN + N_OUT +: N_OUT];
        end else begin
            r_nxt.pout = core_out_in;
            r_nxt.poe_n = core_oe_n_in;
        end
        if (r.ir_lat == IR_HIGHZ) begin
            r_nxt.poe_n = '1;
        end
    end

    // State register.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            r <= '0;
            r.s1 <= PINS_IDLE;
            r.s2 <= PINS_IDLE;
            r.st <= TLR;
            r.ir_lat <= IR_RESET;
            r.tdo_oe_n <= 1'h1;
            r.poe_n <= '1;
        end else begin
            r <= r_nxt;
        end
    end

    assign tdo_out = r.tdo;
    assign tdo_oe_n_out = r.tdo_oe_n;
    assign core_in_out = r.core_in;
    assign pin_out = r.pout;
    assign pin_oe_n_out = r.poe_n;

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    // Counts consecutive rising edges seen with TMS high.
    logic [2:0] tms_cnt;
    always_ff @(posedge mclk_in) begin
        if (rst_in || (rise && !r.s2.tms)) begin
            tms_cnt <= 3'h0;
        end else if (rise && tms_cnt < 3'h5) begin
            tms_cnt <= tms_cnt + 3'h1;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    AST_BYP_CAPTURE: assert property (rise && r.st == CAP_DR && sel == SEL_BYP
        |=> !r.byp)
        else $error("Bypass stage not cleared in Capture-DR.");
    AST_ID_CAPTURE: assert property (rise && r.st == CAP_DR && sel == SEL_ID
        |=> r.id_sh == id_word && r.id_sh[0])
        else $error("Identity word not captured.");
    AST_IR_CAPTURE: assert property (rise && r.st == CAP_IR
        |=> r.ir_sh[1:0] == 2'h1)
        else $error("Capture-IR pattern wrong.");
    AST_IR_HOLD: assert property (!(rise && (r.st == SH_IR || r.st == CAP_IR))
        |=> $stable(r.ir_sh))
        else $error("Instruction shifted outside Shift-IR.");
    AST_IR_UPDATE: assert property (fall && r.st == UPD_IR && !trst
        |=> r.ir_lat == $past(r.ir_sh))
        else $error("Instruction not latched in Update-IR.");
    AST_TLR_IDCODE: assert property (r.st == TLR && (fall || trst)
        |=> r.ir_lat == IR_IDCODE)
        else $error("Reset did not select IDCODE.");
    AST_FIVE_TMS: assert property (tms_cnt == 3'h5 |-> r.st == TLR)
        else $error("Five TMS-high edges did not reset the controller.");
    AST_STATE_RISE: assert property (!rise && !trst |=> $stable(r.st))
        else $error("Controller moved without a rising TCK.");
    AST_TDO_FALL: assert property (!fall |=> $stable(r.tdo) && $stable(r.tdo_oe_n))
        else $error("TDO changed away from falling TCK.");
    AST_TDO_Z: assert property (fall && r.st != SH_IR && r.st != SH_DR
        |=> r.tdo_oe_n)
        else $error("TDO driven outside a shift state.");
    AST_HIGHZ: assert property (r.ir_lat == IR_HIGHZ [*2] |-> &r.poe_n)
        else $error("Outputs enabled under HIGH-Z.");
    AST_FUNC: assert property (r.ir_lat != IR_EXTEST && r.ir_lat != IR_HIGHZ
        |=> r.pout == $past(core_out_in) && r.poe_n == $past(core_oe_n_in))
        else $error("Core outputs disturbed in a functional mode.");

    // Serial paths: each shift moves TDI into the selected register only.
    AST_BYP_SHIFT: assert property (rise && r.st == SH_DR && sel == SEL_BYP
        |=> r.byp == $past(r.s2.tdi))
        else $error("Bypass stage did not take TDI.");
    AST_ID_SHIFT: assert property (rise && r.st == SH_DR && sel == SEL_ID
        |=> r.id_sh[ID_W-1] == $past(r.s2.tdi))
        else $error("Identity word did not shift from TDI.");
    AST_BYP_HOLD: assert property (!(rise && sel == SEL_BYP) |=> $stable(r.byp))
        else $error("Bypass stage moved while not selected.");
    AST_ID_HOLD: assert property (!(rise && sel == SEL_ID) |=> $stable(r.id_sh))
        else $error("Identity word moved while not selected.");

    // TDO launch: the selected register's end bit, driven only while shifting.
    AST_TDO_DRIVE: assert property (fall && (r.st == SH_IR || r.st == SH_DR)
        |=> !r.tdo_oe_n)
        else $error("TDO not driven in a shift state.");
    AST_TDO_PATH: assert property (fall && r.st == SH_DR && sel == SEL_ID
        |=> r.tdo == $past(r.id_sh[0]))
        else $error("TDO does not follow the identity word.");

    // Pins under external test come from the update bank, not from the core.
    AST_EXTEST_PINS: assert property (r.ir_lat == IR_EXTEST
        |=> r.pout == $past(bsr_up[N_IN +: N_OUT])
            && r.poe_n == $past(bsr_up[N_IN + N_OUT +: N_OUT]))
        else $error("External test pins not driven from the chain.");

    // TRST acts one cycle after it is seen, whatever TCK is doing at the time.
    AST_TRST: assert property (trst |=> r.st == TLR && r.ir_lat == IR_IDCODE)
        else $error("TRST did not reset the controller.");

    // Main scenarios that the bench is expected to reach.
    CV_ID_SCAN: cover property (r.st == SH_DR && sel == SEL_ID && fall);
    CV_BYP_SCAN: cover property (r.st == SH_DR && r.ir_lat == IR_BYPASS && fall);
    CV_EXTEST_UPD: cover property (bsr_upd && r.ir_lat == IR_EXTEST);
    CV_HIGHZ: cover property (r.ir_lat == IR_HIGHZ && r.st == SH_DR);
    CV_TRST: cover property (trst && r.st != TLR);

endmodule : jtag_test_port
